// ---- pkg/tcir_regs.svh ----
// Register offsets, reset values and field positions for the trace claim block
// Functional notes
// [RQ1] Integration mode switches at run time, no reset
// [RQ2] Enable bit zero selects functional mode
// [RQ3] Enable bit one selects integration mode
// [RQ4] Without integration support, enable bit reserved zero
// [RQ5] Agent should reset system after integration use
// [RQ6] Claim tags set and cleared independently
// [RQ7] Claim-set read shows implemented tag positions
// [RQ8] Claim-set write one sets, zero keeps
// [RQ9] Claim-clear read shows current tag values
// [RQ10] Claim-clear write one clears, zero keeps
// [RQ11] Tag count implementation chosen, reported by claim-set
// [RQ12] At least four tags recommended
// [RQ13] Capability word seven reads zero always
// [RQ14] Reserved control bits read zero, ignore writes
// [RQ15] Claim tags reset to zero
`ifndef TCIR_REGS_SVH
`define TCIR_REGS_SVH
`define TCIR_OFS_CAP_WORD7    12'h1FC
`define TCIR_OFS_ITGR_CTRL    12'hF00
`define TCIR_OFS_CLAIM_SET    12'hFA0
`define TCIR_OFS_CLAIM_CLR    12'hFA4
`define TCIR_BIT_ITGR_ENABLE  0
`define TCIR_RST_ITGR_CTRL    1'h0
`define TCIR_RST_CLAIM        32'h0000_0000
`define TCIR_VAL_CAP_WORD7    32'h0000_0000
`define TCIR_CLAIM_COUNT      4
`endif

// ---- pkg/tcir_pkg.sv ----
// Types shared by the trace claim and integration register block
package tcir_pkg;
  typedef logic [31:0] tcir_word_t;
  typedef enum logic [1:0] {
    TCIR_SEL_NONE = 2'h0,
    TCIR_SEL_HIT  = 2'h1
  } tcir_sel_t;
endpackage

// ---- logic/tcir_regs_top.sv ----
// APB register bank: capability word, integration control, claim tags
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "tcir_regs.svh"
module tcir_regs_top #(
  parameter int CLAIM_COUNT     = `TCIR_CLAIM_COUNT,
  parameter bit ITGR_SUPPORTED  = 1'b1
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             integration_mode_enable_out,
  output logic      [31:0] claim_tags_out
);
  // Mask of implemented claim positions
  localparam tcir_pkg::tcir_word_t IMPL_MASK = (CLAIM_COUNT >= 32) ? 32'hFFFF_FFFF :
                                               tcir_pkg::tcir_word_t'((64'h1 << CLAIM_COUNT) - 64'h1);

  logic        ime_r;
  logic [31:0] claim_r;
  logic [31:0] claim_nxt;
  logic [31:0] rdata_nxt;

  // Decode; one-cycle access, so pready answers in the setup-following cycle
  wire setup_w   = psel_in & ~penable_in;
  wire access_w  = psel_in & penable_in & pready_out;
  wire hit_cap   = paddr_in == `TCIR_OFS_CAP_WORD7;
  wire hit_ctrl  = paddr_in == `TCIR_OFS_ITGR_CTRL;
  wire hit_set   = paddr_in == `TCIR_OFS_CLAIM_SET;
  wire hit_clr   = paddr_in == `TCIR_OFS_CLAIM_CLR;
  wire hit_any   = hit_cap | hit_ctrl | hit_set | hit_clr;
  wire wr_w      = access_w & pwrite_in;
  wire wr_ctrl   = wr_w & hit_ctrl;
  wire wr_set    = wr_w & hit_set;
  wire wr_clr    = wr_w & hit_clr;

  // Set and clear touch only implemented positions; unimplemented stay zero
  assign claim_nxt = wr_set ? (claim_r | (pwdata_in & IMPL_MASK)) :          // RQ8 RQ6
                     wr_clr ? (claim_r & ~(pwdata_in & IMPL_MASK)) :         // RQ10 RQ6
                     claim_r;

  // Read mux, reserved bits zero
  assign rdata_nxt = hit_ctrl ? {31'h0000_0000, ime_r} :                     // RQ14
                     hit_set  ? IMPL_MASK :                                  // RQ7 RQ11 RQ12
                     hit_clr  ? claim_r :                                    // RQ9
                     hit_cap  ? `TCIR_VAL_CAP_WORD7 :                        // RQ13
                     32'h0000_0000;

  // Integration enable, live switch without reset
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ime_r <= `TCIR_RST_ITGR_CTRL;
    end else if (wr_ctrl) begin
      ime_r <= ITGR_SUPPORTED & pwdata_in[`TCIR_BIT_ITGR_ENABLE];            // RQ1 RQ2 RQ3 RQ4
    end
  end

  // Claim tags
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      claim_r <= `TCIR_RST_CLAIM;                                            // RQ15
    end else begin
      claim_r <= claim_nxt;
    end
  end

  // Bus answer registers: ready follows setup by one cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= setup_w;
      pslverr_out <= setup_w & ~hit_any;
      prdata_out  <= (setup_w & ~pwrite_in) ? rdata_nxt : 32'h0000_0000;
    end
  end

  // Mirrors of state for the surrounding unit
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      integration_mode_enable_out <= 1'b0;
      claim_tags_out              <= 32'h0000_0000;
    end else begin
      integration_mode_enable_out <= ime_r;
      claim_tags_out              <= claim_r;
    end
  end

  // Checks
  sequence s_set_write;
    psel_in && penable_in && pready_out && pwrite_in && hit_set;
  endsequence

  sequence s_clr_write;
    psel_in && penable_in && pready_out && pwrite_in && hit_clr;
  endsequence

  a_claim_set_ones: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ8
    s_set_write |=> ((claim_r & ($past(pwdata_in) & IMPL_MASK)) == ($past(pwdata_in) & IMPL_MASK)))
    else $error("claim set did not set tags");
  a_claim_set_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ8
    s_set_write |=> ((claim_r & ~$past(pwdata_in)) == ($past(claim_r) & ~$past(pwdata_in))))
    else $error("claim set changed unwritten tags");
  a_claim_clr_ones: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ10
    s_clr_write |=> ((claim_r & $past(pwdata_in)) == 32'h0000_0000))
    else $error("claim clear did not clear tags");
  a_claim_clr_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ10
    s_clr_write |=> ((claim_r & ~$past(pwdata_in)) == ($past(claim_r) & ~$past(pwdata_in))))
    else $error("claim clear changed unwritten tags");
  a_claim_impl_only: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ14
    (claim_r & ~IMPL_MASK) == 32'h0000_0000)
    else $error("unimplemented claim tag set");
  a_set_read_mask: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ7
    (setup_w && !pwrite_in && hit_set) |=> (prdata_out == IMPL_MASK && pready_out))
    else $error("claim set read wrong");
  a_clr_read_tags: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ9
    (setup_w && !pwrite_in && hit_clr) |=> (prdata_out == claim_r))
    else $error("claim clear read wrong");
  a_cap_read_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ13
    (setup_w && hit_cap) |=> (prdata_out == 32'h0000_0000 && !pslverr_out))
    else $error("capability word not zero");
  a_ime_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ1
    (wr_ctrl) |=> (ime_r == (ITGR_SUPPORTED & $past(pwdata_in[0]))) ##1 integration_mode_enable_out == ime_r)
    else $error("integration enable did not follow write");
  a_ime_reserved: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ4
    !ITGR_SUPPORTED |-> !ime_r)
    else $error("integration enable set without support");
  a_ctrl_read_bits: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ14
    (setup_w && !pwrite_in && hit_ctrl) |=> (prdata_out[31:1] == 31'h0000_0000 && prdata_out[0] == ime_r))
    else $error("control read wrong");

  // First edge after reset; only the checks below read it
  logic fresh_rst_r;

  // Cleared on the first running edge, so it flags exactly one cycle
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fresh_rst_r <= 1'b1;
    end else begin
      fresh_rst_r <= 1'b0;
    end
  end

  // Transfer steps as the bank sees them
  sequence s_any_setup;
    psel_in && !penable_in;
  endsequence

  sequence s_write_setup;
    psel_in && !penable_in && pwrite_in;
  endsequence

  sequence s_unmapped_setup;
    psel_in && !penable_in && !hit_any;
  endsequence

  sequence s_mapped_setup;
    psel_in && !penable_in && hit_any;
  endsequence

  sequence s_set_read;
    psel_in && !penable_in && !pwrite_in && hit_set;
  endsequence

  sequence s_clr_read;
    psel_in && !penable_in && !pwrite_in && hit_clr;
  endsequence

  sequence s_ctrl_read;
    psel_in && !penable_in && !pwrite_in && hit_ctrl;
  endsequence

  sequence s_ctrl_write;
    psel_in && penable_in && pready_out && pwrite_in && hit_ctrl;
  endsequence

  sequence s_access;
    psel_in && penable_in;
  endsequence

  // Handshake: each setup earns one ready, never a wait state
  a_ready_after_setup: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_any_setup |=> pready_out)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pready_out |=> !pready_out)
    else $error("ready held too long");
  a_ready_in_access: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_access |-> pready_out)
    else $error("access cycle without ready");
  a_ready_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !psel_in |=> !pready_out)
    else $error("ready without a request");

  // Error only for holes in the map, and only with ready
  a_err_unmapped: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_unmapped_setup |=> (pslverr_out && prdata_out == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_err_mapped: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_mapped_setup |=> !pslverr_out)
    else $error("mapped access refused");
  a_err_with_ready: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pslverr_out |-> pready_out)
    else $error("error without ready");

  // Read data is zero outside a read answer, so stale words never leak
  a_rdata_idle_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !pready_out |-> (prdata_out == 32'h0000_0000))
    else $error("read data outside answer");
  a_wr_rdata_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    s_write_setup |=> (prdata_out == 32'h0000_0000))
    else $error("read data on a write");

  // Writes to nothing writable leave all state alone
  a_hole_wr_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (wr_w && !hit_any) |=> (claim_r == $past(claim_r) && ime_r == $past(ime_r)))
    else $error("unmapped write changed state");
  a_cap_wr_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ13
    (wr_w && hit_cap) |=> (claim_r == $past(claim_r) && ime_r == $past(ime_r)))
    else $error("capability write changed state");

  // Integration enable: set, clear, hold and mirror
  a_ime_set_one: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ3
    (wr_ctrl && pwdata_in[`TCIR_BIT_ITGR_ENABLE] && ITGR_SUPPORTED) |=> ime_r)
    else $error("integration mode not entered");
  a_ime_clr_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ2
    (wr_ctrl && !pwdata_in[`TCIR_BIT_ITGR_ENABLE]) |=> !ime_r)
    else $error("functional mode not entered");
  a_ime_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ1
    !wr_ctrl |=> (ime_r == $past(ime_r)))
    else $error("integration enable moved without write");
  a_ime_mirror: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ1
    integration_mode_enable_out == $past(ime_r))
    else $error("integration enable output lags wrongly");

  // Claim tags: quiet without a claim write, mirrored one cycle late
  a_claim_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ6
    (!wr_set && !wr_clr) |=> (claim_r == $past(claim_r)))
    else $error("claim tags moved without write");
  a_ctrl_wr_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ6
    s_ctrl_write |=> (claim_r == $past(claim_r)))
    else $error("control write changed claim tags");
  a_tags_mirror: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ6
    claim_tags_out == $past(claim_r))
    else $error("claim tag output lags wrongly");

  // First edge after reset: nothing claimed, functional mode
  a_claim_rst_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ15
    fresh_rst_r |-> (claim_r == 32'h0000_0000 && claim_tags_out == 32'h0000_0000))
    else $error("claim tags not zero after reset");
  a_ime_rst_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    fresh_rst_r |-> (!ime_r && !integration_mode_enable_out))
    else $error("integration enable not zero after reset");

  // Per-position claim checks; unimplemented positions stay dead
  for (genvar tag_idx = 0; tag_idx < 32; tag_idx = tag_idx + 1) begin : g_tag_chk
    if (IMPL_MASK[tag_idx]) begin : g_impl
      a_tag_set_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ8
        (wr_set && pwdata_in[tag_idx]) |=> claim_r[tag_idx])
        else $error("claim tag not set");
      a_tag_set_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ8
        (wr_set && !pwdata_in[tag_idx]) |=> (claim_r[tag_idx] == $past(claim_r[tag_idx])))
        else $error("claim set zero bit changed tag");
      a_tag_clr_bit: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ10
        (wr_clr && pwdata_in[tag_idx]) |=> !claim_r[tag_idx])
        else $error("claim tag not cleared");
      a_tag_clr_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ10
        (wr_clr && !pwdata_in[tag_idx]) |=> (claim_r[tag_idx] == $past(claim_r[tag_idx])))
        else $error("claim clear zero bit changed tag");
      a_tag_rd_impl: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ7
        s_set_read |=> prdata_out[tag_idx])
        else $error("implemented tag reads absent");
      a_tag_rd_clr: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ9
        s_clr_read |=> (prdata_out[tag_idx] == $past(claim_r[tag_idx])))
        else $error("claim clear read shows wrong tag");
    end else begin : g_unimpl
      a_tag_rd_absent: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ7
        s_set_read |=> !prdata_out[tag_idx])
        else $error("absent tag reads implemented");
      a_tag_dead: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ14
        (!claim_r[tag_idx] && !claim_tags_out[tag_idx]))
        else $error("absent tag became set");
    end
  end

  // Four tags at least, as recommended; smaller builds skip this check
  if (CLAIM_COUNT >= 4) begin : g_four_tags
    a_four_tags: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ12
      s_set_read |=> (prdata_out[3:0] == 4'hF))
      else $error("fewer than four tags reported");
  end

  // Without integration support the enable bit is dead in every view
  if (!ITGR_SUPPORTED) begin : g_no_itgr
    a_ime_rsvd_rd: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ4
      s_ctrl_read |=> (prdata_out == 32'h0000_0000))
      else $error("reserved enable bit reads one");
    a_ime_out_dead: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ4
      !integration_mode_enable_out)
      else $error("reserved enable output set");
  end
endmodule

// ---- verification/tcir_apb_agent.sv ----
// APB debug agent model that drives the register bank
`timescale 1ns/1ns
module tcir_apb_agent (
  input  wire logic        clk_in,
  input  wire logic        pready_in,
  input  wire logic        pslverr_in,
  input  wire logic [31:0] prdata_in,
  output logic             psel_out,
  output logic             penable_out,
  output logic             pwrite_out,
  output logic      [11:0] paddr_out,
  output logic      [31:0] pwdata_out
);
  initial {psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
  // One transfer, any answer delay; the answer is taken at the ready edge itself
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel_out <= 1'h1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge clk_in);
    penable_out <= 1'h1;
    // Read on wake-up gives pre-edge values, as the bank updates by non-blocking assignment
    forever begin
      @(posedge clk_in);
      if (pready_in === 1'h1) begin
        q = prdata_in;
        e = pslverr_in;
        break;
      end
    end
    psel_out <= 1'h0;
    penable_out <= 1'h0;
    pwdata_out <= ~d; // Stale data never looks valid
    @(posedge clk_in);
  endtask
endmodule

// ---- verification/trace_claim_and_integration_regs_test.sv ----
// Self-checking bench for the claim and integration register bank
`timescale 1ns/1ns
`include "tcir_regs.svh"
module trace_claim_and_integration_regs_test;
  localparam logic [11:0] CAP = `TCIR_OFS_CAP_WORD7;
  localparam logic [11:0] CTL = `TCIR_OFS_ITGR_CTRL;
  localparam logic [11:0] SET = `TCIR_OFS_CLAIM_SET;
  localparam logic [11:0] CLR = `TCIR_OFS_CLAIM_CLR;
  logic        clk, rst, psel, pen, pwr, rdy, err, integration_mode_enable;
  logic [11:0] addr;
  logic [31:0] wd, rdat, tags, q;
  int          error_cnt = 0, num_checks = 0, cyc = 0;
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  tcir_regs_top DUT (.clk_in(clk), .sys_rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(addr), .pwdata_in(wd), .prdata_out(rdat), .pready_out(rdy), .pslverr_out(err),
    .integration_mode_enable_out(integration_mode_enable), .claim_tags_out(tags));
  tcir_apb_agent m (.clk_in(clk), .pready_in(rdy), .pslverr_in(err), .prdata_in(rdat), .psel_out(psel),
    .penable_out(pen), .pwrite_out(pwr), .paddr_out(addr), .pwdata_out(wd));
  logic        ime_n;
  logic [31:0] tags_n;
  // Eight tags and no integration support, listening on the same bus
  tcir_regs_top #(.CLAIM_COUNT(8), .ITGR_SUPPORTED(1'b0)) DUT_NOITG (.clk_in(clk), .sys_rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wd), .prdata_out(),
    .pready_out(), .pslverr_out(), .integration_mode_enable_out(ime_n), .claim_tags_out(tags_n));
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Transfer plus error flag check; reads also compare data
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, e, input logic x);
    logic s;
    m.xfer(w, a, d, q, s);
    chk({31'h0, s}, {31'h0, x});
    if (!w) chk(q, e);
  endtask
  task automatic do_rst;
    rst <= 1'h1;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
  endtask
  task automatic t_reset;
    acc(1'h0, CAP, 32'h0, 32'h0, 1'h0);
    acc(1'h0, CTL, 32'h0, 32'h0, 1'h0);
    acc(1'h0, CLR, 32'h0, 32'h0, 1'h0);
    acc(1'h0, SET, 32'h0, 32'hF, 1'h0);
    $display("reset values done");
  endtask
  task automatic t_itgr;
    acc(1'h1, CTL, 32'hFFFF_FFFF, 32'h0, 1'h0);
    @(negedge clk);
    chk({31'h0, integration_mode_enable}, 32'h1);
    chk({31'h0, ime_n}, 32'h0);
    acc(1'h0, CTL, 32'h0, 32'h1, 1'h0);
    acc(1'h1, CTL, 32'hFFFF_FFFE, 32'h0, 1'h0);
    acc(1'h0, CTL, 32'h0, 32'h0, 1'h0);
    acc(1'h1, CAP, 32'hFFFF_FFFF, 32'h0, 1'h0);
    acc(1'h0, CAP, 32'h0, 32'h0, 1'h0);
    $display("integration mode done");
  endtask
  task automatic t_claim;
    acc(1'h1, SET, 32'hFFFF_FFF5, 32'h0, 1'h0);
    acc(1'h1, SET, 32'h0, 32'h0, 1'h0);
    acc(1'h0, CLR, 32'h0, 32'h5, 1'h0);
    acc(1'h1, CLR, 32'h4, 32'h0, 1'h0);
    acc(1'h1, CLR, 32'h0, 32'h0, 1'h0);
    acc(1'h0, CLR, 32'h0, 32'h1, 1'h0);
    @(negedge clk);
    chk(tags, 32'h1);
    chk(tags_n, 32'hF1);
    acc(1'h1, 12'h004, 32'hF, 32'h0, 1'h1); // Unmapped write refused
    acc(1'h0, 12'h004, 32'h0, 32'h0, 1'h1); // Unmapped read refused
    acc(1'h0, SET, 32'h0, 32'hF, 1'h0);
    $display("claim tags done");
  endtask
  task automatic t_rerun;
    acc(1'h1, CTL, 32'h1, 32'h0, 1'h0);
    acc(1'h1, SET, 32'h2, 32'h0, 1'h0);
    do_rst;
    acc(1'h0, CLR, 32'h0, 32'h0, 1'h0);
    acc(1'h0, CTL, 32'h0, 32'h0, 1'h0);
    $display("reset after integration done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    rst = 1'h1;
    do_rst;
    t_reset;
    t_itgr;
    t_claim;
    t_rerun;
    results;
  end
  // Hang guard, far above the roughly 115 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      results;
    end
  end
endmodule
